/* File: rtl/afr_pkg.sv */
// afr_pkg: register offsets, field positions, reset values and fault indices
// for the amplifier fault report register bank.
// assumes an 8-bit register address space and 8-bit data.
package afr_pkg;

  localparam int AW = 8;
  localparam int DW = 8;

  // register offsets
  localparam logic [AW-1:0] OFS_CHANNEL_FAULT    = 8'h70;
  localparam logic [AW-1:0] OFS_GLOBAL_FAULT     = 8'h71;
  localparam logic [AW-1:0] OFS_THERMAL_SHUTDOWN = 8'h72;
  localparam logic [AW-1:0] OFS_THERMAL_WARNING  = 8'h73;
  localparam logic [AW-1:0] OFS_FAULT_MASK       = 8'h74;
  localparam logic [AW-1:0] OFS_LATCH_CONFIG     = 8'h75;
  localparam logic [AW-1:0] OFS_MISC_CONFIG      = 8'h76;
  localparam logic [AW-1:0] OFS_FAULT_CLEAR      = 8'h78;

  // reset values
  localparam logic [DW-1:0] RST_FAULT_MASK   = 8'h00;
  localparam logic [DW-1:0] RST_LATCH_CONFIG = 8'hf8;
  localparam logic [DW-1:0] RST_MISC_CONFIG  = 8'h00;
  localparam logic [DW-1:0] RST_FAULT_CLEAR  = 8'h00;
  localparam logic [DW-1:0] ZERO_BYTE        = 8'h00;

  // channel fault register fields
  localparam int BIT_RIGHT_OVERCURRENT = 0;
  localparam int BIT_LEFT_OVERCURRENT  = 1;
  localparam int BIT_RIGHT_OFFSET      = 2;
  localparam int BIT_LEFT_OFFSET       = 3;
  // global fault register fields
  localparam int BIT_POWER_LOW         = 0;
  localparam int BIT_POWER_HIGH        = 1;
  localparam int BIT_CLOCK_FAULT       = 2;
  // thermal status fields
  localparam int BIT_THERMAL_SHUTDOWN  = 0;
  localparam int BIT_THERMAL_WARNING   = 2;

  // fault report mask fields
  localparam int BIT_SUPPRESS_OVERCURRENT = 0;
  localparam int BIT_SUPPRESS_OFFSET      = 1;
  localparam int BIT_SUPPRESS_POWER_HIGH  = 2;
  localparam int BIT_SUPPRESS_POWER_LOW   = 3;
  localparam int BIT_SUPPRESS_CLOCK       = 4;
  localparam int BIT_SUPPRESS_CORE_HIGH   = 5;
  localparam int BIT_SUPPRESS_CORE_LOW    = 6;
  localparam int BIT_SUPPRESS_SHUTDOWN    = 7;

  // latch config fields
  localparam int BIT_SUPPRESS_WARNING     = 2;
  localparam int BIT_HOLD_WARNING         = 3;
  localparam int BIT_HOLD_SHUTDOWN        = 4;
  localparam int BIT_HOLD_CLOCK           = 5;

  // misc config fields
  localparam int BIT_SELF_RECOVERY        = 4;
  localparam int BIT_HOLD_CLOCK_DETECT    = 7;

  // fault clear command field
  localparam int BIT_ANALOG_FAULT_CLEAR   = 7;

  // fault indices into the internal flag vector
  localparam int NUM_FAULTS      = 11;
  localparam int F_OC_RIGHT      = 0;
  localparam int F_OC_LEFT       = 1;
  localparam int F_DC_RIGHT      = 2;
  localparam int F_DC_LEFT       = 3;
  localparam int F_POWER_LOW     = 4;
  localparam int F_POWER_HIGH    = 5;
  localparam int F_CLOCK         = 6;
  localparam int F_CORE_LOW      = 7;
  localparam int F_CORE_HIGH     = 8;
  localparam int F_SHUTDOWN      = 9;
  localparam int F_WARNING       = 10;

endpackage

/* File: rtl/afr_fault_cell.sv */
// afr_fault_cell: one fault input, synchronised and optionally held.
// assumes the raw fault is asynchronous to mclk and active high.
`timescale 1ns/1ps
module afr_fault_cell (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // fault source and control
  input  wire logic raw_fault,
  input  wire logic hold,
  input  wire logic clear,
  // result
  output logic      live,
  output logic      flag
);

  logic sync_first;

  always_ff @(posedge mclk) begin
    if (reset) begin
      sync_first <= 1'b0;
      live       <= 1'b0;
    end else begin
      sync_first <= raw_fault;
      live       <= sync_first;
    end
  end

  // a present fault wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      flag <= 1'b0;
    end else begin
      flag <= live | (flag & hold & ~clear);
    end
  end

endmodule

/* File: rtl/afr_regs.sv */
// afr_regs: fault status, report masking, latching and clear register bank.
// assumes a register access port from a same-clock control interface
// and raw fault levels from analog sensing, asynchronous to mclk.
//
// Contract
// - thermal shutdown flag, bit0 at 72h, rest zero
// - thermal warning flag, bit2 at 73h
// - mask bit7 suppresses thermal shutdown report
// - mask bit6 suppresses core undervoltage report
// - mask bit5 suppresses core overvoltage report
// - mask bit4 suppresses clock fault report
// - mask bit3 suppresses power undervoltage report
// - mask bit2 suppresses power overvoltage report
// - mask bit1 suppresses output offset report
// - mask bit0 suppresses overcurrent report
// - 75h bit5 holds clock fault
// - 75h bit4 holds thermal shutdown
// - 75h bit3 holds thermal warning
// - 75h bit2 suppresses thermal warning report
// - 76h bit7 holds clock detect status
// - 76h bit4 enables thermal shutdown self recovery
// - write one to 78h bit7 clears faults
// - per channel offset, overcurrent flags at 70h
`timescale 1ns/1ps
module afr_regs (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset,
  // register access port
  input  wire logic [afr_pkg::AW-1:0] reg_addr,
  input  wire logic [afr_pkg::DW-1:0] reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [afr_pkg::DW-1:0] reg_rdata,
  output logic                       reg_rvalid,
  // raw fault levels from sensing
  input  wire logic                  left_overcurrent_raw,
  input  wire logic                  right_overcurrent_raw,
  input  wire logic                  left_offset_raw,
  input  wire logic                  right_offset_raw,
  input  wire logic                  power_supply_low_raw,
  input  wire logic                  power_supply_high_raw,
  input  wire logic                  clock_failure_raw,
  input  wire logic                  core_supply_low_raw,
  input  wire logic                  core_supply_high_raw,
  input  wire logic                  thermal_shutdown_raw,
  input  wire logic                  thermal_warning_raw,
  // fault report and control
  output logic                       fault_report_n,
  output logic                       thermal_warning_report_n,
  output logic                       thermal_shutdown_active,
  output logic                       analog_fault_clear
);

  import afr_pkg::*;

  logic [DW-1:0]         fault_report_mask;
  logic [DW-1:0]         fault_latch_config;
  logic [DW-1:0]         misc_fault_config;
  logic [DW-1:0]         fault_clear_command;
  logic [NUM_FAULTS-1:0] raw_vec;
  logic [NUM_FAULTS-1:0] hold_vec;
  logic [NUM_FAULTS-1:0] flag_vec;
  logic [NUM_FAULTS-1:0] suppress_vec;
  logic [DW-1:0]         next_rdata;

  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // register writes
  wire write_mask  = reg_write & hit(reg_addr, OFS_FAULT_MASK);
  wire write_latch = reg_write & hit(reg_addr, OFS_LATCH_CONFIG);
  wire write_misc  = reg_write & hit(reg_addr, OFS_MISC_CONFIG);
  wire write_clear = reg_write & hit(reg_addr, OFS_FAULT_CLEAR);
  wire clear_req   = write_clear & reg_wdata[BIT_ANALOG_FAULT_CLEAR];
  // the command bit is never stored, so no write of zero is needed
  wire [DW-1:0] clear_keep = ~(DW'(1) << BIT_ANALOG_FAULT_CLEAR);

  always_ff @(posedge mclk) begin
    if (reset) begin
      fault_report_mask <= RST_FAULT_MASK;
    end else if (write_mask) begin
      fault_report_mask <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fault_latch_config <= RST_LATCH_CONFIG;
    end else if (write_latch) begin
      fault_latch_config <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      misc_fault_config <= RST_MISC_CONFIG;
    end else if (write_misc) begin
      misc_fault_config <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fault_clear_command <= RST_FAULT_CLEAR;
    end else if (write_clear) begin
      fault_clear_command <= reg_wdata & clear_keep;
    end
  end

  // clear command pulse, one cycle after the write
  always_ff @(posedge mclk) begin
    if (reset) begin
      analog_fault_clear <= 1'b0;
    end else begin
      analog_fault_clear <= clear_req;
    end
  end

  // control decoding
  wire hold_clock_failure     = fault_latch_config[BIT_HOLD_CLOCK];
  wire hold_thermal_shutdown  = fault_latch_config[BIT_HOLD_SHUTDOWN];
  wire hold_thermal_warning   = fault_latch_config[BIT_HOLD_WARNING];
  wire suppress_warning       = fault_latch_config[BIT_SUPPRESS_WARNING];
  wire hold_clock_detect      = misc_fault_config[BIT_HOLD_CLOCK_DETECT];
  wire thermal_self_recovery  = misc_fault_config[BIT_SELF_RECOVERY];

  assign raw_vec[F_OC_RIGHT]   = right_overcurrent_raw;
  assign raw_vec[F_OC_LEFT]    = left_overcurrent_raw;
  assign raw_vec[F_DC_RIGHT]   = right_offset_raw;
  assign raw_vec[F_DC_LEFT]    = left_offset_raw;
  assign raw_vec[F_POWER_LOW]  = power_supply_low_raw;
  assign raw_vec[F_POWER_HIGH] = power_supply_high_raw;
  assign raw_vec[F_CLOCK]      = clock_failure_raw;
  assign raw_vec[F_CORE_LOW]   = core_supply_low_raw;
  assign raw_vec[F_CORE_HIGH]  = core_supply_high_raw;
  assign raw_vec[F_SHUTDOWN]   = thermal_shutdown_raw;
  assign raw_vec[F_WARNING]    = thermal_warning_raw;

  // channel, power supply and core supply faults always hold until cleared
  assign hold_vec[F_OC_RIGHT]   = 1'b1;
  assign hold_vec[F_OC_LEFT]    = 1'b1;
  assign hold_vec[F_DC_RIGHT]   = 1'b1;
  assign hold_vec[F_DC_LEFT]    = 1'b1;
  assign hold_vec[F_POWER_LOW]  = 1'b1;
  assign hold_vec[F_POWER_HIGH] = 1'b1;
  assign hold_vec[F_CORE_LOW]   = 1'b1;
  assign hold_vec[F_CORE_HIGH]  = 1'b1;
  assign hold_vec[F_CLOCK]      = hold_clock_failure | hold_clock_detect;
  // self recovery releases the shutdown flag once the die cools
  assign hold_vec[F_SHUTDOWN]   = hold_thermal_shutdown & ~thermal_self_recovery;
  assign hold_vec[F_WARNING]    = hold_thermal_warning;

  // report suppression per fault
  assign suppress_vec[F_OC_RIGHT]   = fault_report_mask[BIT_SUPPRESS_OVERCURRENT];
  assign suppress_vec[F_OC_LEFT]    = fault_report_mask[BIT_SUPPRESS_OVERCURRENT];
  assign suppress_vec[F_DC_RIGHT]   = fault_report_mask[BIT_SUPPRESS_OFFSET];
  assign suppress_vec[F_DC_LEFT]    = fault_report_mask[BIT_SUPPRESS_OFFSET];
  assign suppress_vec[F_POWER_HIGH] = fault_report_mask[BIT_SUPPRESS_POWER_HIGH];
  assign suppress_vec[F_POWER_LOW]  = fault_report_mask[BIT_SUPPRESS_POWER_LOW];
  assign suppress_vec[F_CLOCK]      = fault_report_mask[BIT_SUPPRESS_CLOCK];
  assign suppress_vec[F_CORE_HIGH]  = fault_report_mask[BIT_SUPPRESS_CORE_HIGH];
  assign suppress_vec[F_CORE_LOW]   = fault_report_mask[BIT_SUPPRESS_CORE_LOW];
  assign suppress_vec[F_SHUTDOWN]   = fault_report_mask[BIT_SUPPRESS_SHUTDOWN];
  assign suppress_vec[F_WARNING]    = suppress_warning;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FAULTS; gi = gi + 1) begin : g_cell
      afr_fault_cell u_cell (
        .mclk      (mclk),
        .reset     (reset),
        .raw_fault (raw_vec[gi]),
        .hold      (hold_vec[gi]),
        .clear     (clear_req),
        .live      (),
        .flag      (flag_vec[gi])
      );
    end
  endgenerate

  // the warning has its own report line; the main line carries the rest
  wire [NUM_FAULTS-1:0] reported = flag_vec & ~suppress_vec;
  wire main_report    = |reported[F_SHUTDOWN:F_OC_RIGHT];
  wire warning_report = reported[F_WARNING];

  always_ff @(posedge mclk) begin
    if (reset) begin
      fault_report_n <= 1'b1;
    end else begin
      fault_report_n <= ~main_report;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      thermal_warning_report_n <= 1'b1;
    end else begin
      thermal_warning_report_n <= ~warning_report;
    end
  end

  // shutdown acts on the flag whatever the mask says
  always_ff @(posedge mclk) begin
    if (reset) begin
      thermal_shutdown_active <= 1'b0;
    end else begin
      thermal_shutdown_active <= flag_vec[F_SHUTDOWN];
    end
  end

  // read decoding, status shows flags regardless of masks
  always_comb begin
    next_rdata = ZERO_BYTE;
    case (reg_addr)
      OFS_CHANNEL_FAULT: begin
        next_rdata[BIT_RIGHT_OVERCURRENT] = flag_vec[F_OC_RIGHT];
        next_rdata[BIT_LEFT_OVERCURRENT]  = flag_vec[F_OC_LEFT];
        next_rdata[BIT_RIGHT_OFFSET]      = flag_vec[F_DC_RIGHT];
        next_rdata[BIT_LEFT_OFFSET]       = flag_vec[F_DC_LEFT];
      end
      OFS_GLOBAL_FAULT: begin
        next_rdata[BIT_POWER_LOW]   = flag_vec[F_POWER_LOW];
        next_rdata[BIT_POWER_HIGH]  = flag_vec[F_POWER_HIGH];
        next_rdata[BIT_CLOCK_FAULT] = flag_vec[F_CLOCK];
      end
      OFS_THERMAL_SHUTDOWN: begin
        next_rdata[BIT_THERMAL_SHUTDOWN] = flag_vec[F_SHUTDOWN];
      end
      OFS_THERMAL_WARNING: begin
        next_rdata[BIT_THERMAL_WARNING] = flag_vec[F_WARNING];
      end
      OFS_FAULT_MASK:   next_rdata = fault_report_mask;
      OFS_LATCH_CONFIG: next_rdata = fault_latch_config;
      OFS_MISC_CONFIG:  next_rdata = misc_fault_config;
      OFS_FAULT_CLEAR:  next_rdata = fault_clear_command;
      default:          next_rdata = ZERO_BYTE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
    end
  end

  // read data stands until the next read
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= ZERO_BYTE;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

/* File: verification/afr_regs_checker.sv */
// afr_regs_checker: port-level assertions for the fault report register bank.
// assumes it is bound to afr_regs and sees only that module's ports.
`timescale 1ns/1ps
module afr_regs_checker (
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    reset,
  // register access port
  input wire logic [afr_pkg::AW-1:0]  reg_addr,
  input wire logic [afr_pkg::DW-1:0]  reg_wdata,
  input wire logic                    reg_write,
  input wire logic                    reg_read,
  input wire logic [afr_pkg::DW-1:0]  reg_rdata,
  input wire logic                    reg_rvalid,
  // report and control
  input wire logic                    fault_report_n,
  input wire logic                    thermal_warning_report_n,
  input wire logic                    thermal_shutdown_active,
  input wire logic                    analog_fault_clear
);
  // mirrors of the writable mask and latch registers
  logic [7:0] mask_q;
  logic [7:0] cfg_q;
  always_ff @(posedge mclk) begin
    if (reset) begin
      mask_q <= 8'h00;
      cfg_q  <= 8'hf8;
    end else if (reg_write && reg_addr == 8'h74) begin
      mask_q <= reg_wdata;
    end else if (reg_write && reg_addr == 8'h75) begin
      cfg_q <= reg_wdata;
    end
  end
  wire clear_cmd = reg_write && reg_addr == 8'h78 && reg_wdata[7];
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_shutdown_reg_zero : assert property (
    reg_read && reg_addr == 8'h72 |=> reg_rvalid && reg_rdata[7:1] == 7'h00)
    else $error("shutdown status upper bits set");
  a_warn_reg_zero : assert property (
    reg_read && reg_addr == 8'h73 |=> reg_rvalid && (reg_rdata & 8'hfb) == 8'h00)
    else $error("warning status spare bits set");
  a_chan_reg_zero : assert property (
    reg_read && reg_addr == 8'h70 |=> reg_rvalid && reg_rdata[7:4] == 4'h0)
    else $error("channel fault spare bits set");
  a_mask_read_back : assert property (
    reg_read && reg_addr == 8'h74 |=> reg_rdata == $past(mask_q))
    else $error("mask register readback wrong");
  a_latch_read_back : assert property (
    reg_read && reg_addr == 8'h75 |=> reg_rdata == $past(cfg_q))
    else $error("latch config readback wrong");
  a_shutdown_report : assert property (
    thermal_shutdown_active && !$past(mask_q[7]) |-> !fault_report_n)
    else $error("unmasked shutdown not reported");
  a_warn_suppress : assert property (
    !thermal_warning_report_n |-> !$past(cfg_q[2]))
    else $error("suppressed warning reported");
  a_clear_pulse : assert property (
    clear_cmd |=> analog_fault_clear)
    else $error("clear pulse missing");
  a_clear_cause : assert property (
    analog_fault_clear |-> $past(clear_cmd))
    else $error("clear pulse without command");
  a_rvalid_follow : assert property (
    reg_rvalid == $past(reg_read))
    else $error("read valid not one cycle after read");
endmodule
bind afr_regs afr_regs_checker chk_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fault_report_n(fault_report_n),
  .thermal_warning_report_n(thermal_warning_report_n),
  .thermal_shutdown_active(thermal_shutdown_active), .analog_fault_clear(analog_fault_clear));

/* File: verification/afr_regs_test.sv */
// afr_regs_test: self-checking bench for the fault report register bank.
// assumes afr_pkg and afr_regs are compiled first; 25 MHz mclk.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module afr_regs_test;
  import afr_pkg::*;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [10:0] raw = 11'h000;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid, fault_report_n, thermal_warning_report_n;
  logic        thermal_shutdown_active, analog_fault_clear;
  logic [31:0] seed = 32'h3155_7947;
  logic [31:0] r;
  logic [7:0]  c5[4] = '{8'hf8, 8'hc0, 8'hf8, 8'hc0};
  logic [7:0]  c6[4] = '{8'h00, 8'h00, 8'h10, 8'h80};
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #20 mclk = ~mclk;
  afr_regs dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .left_overcurrent_raw(raw[F_OC_LEFT]), .right_overcurrent_raw(raw[F_OC_RIGHT]),
    .left_offset_raw(raw[F_DC_LEFT]), .right_offset_raw(raw[F_DC_RIGHT]),
    .power_supply_low_raw(raw[F_POWER_LOW]), .power_supply_high_raw(raw[F_POWER_HIGH]),
    .clock_failure_raw(raw[F_CLOCK]), .core_supply_low_raw(raw[F_CORE_LOW]),
    .core_supply_high_raw(raw[F_CORE_HIGH]), .thermal_shutdown_raw(raw[F_SHUTDOWN]),
    .thermal_warning_raw(raw[F_WARNING]), .fault_report_n(fault_report_n),
    .thermal_warning_report_n(thermal_warning_report_n),
    .thermal_shutdown_active(thermal_shutdown_active), .analog_fault_clear(analog_fault_clear));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // status register and bit that record fault i; core supply faults have none
  function automatic logic [7:0] addr_of(int i);
    if (i < 4) return 8'h70;
    if (i < 7) return 8'h71;
    if (i == F_SHUTDOWN) return 8'h72;
    return (i == F_WARNING) ? 8'h73 : 8'h00;
  endfunction
  function automatic logic [7:0] byte_of(int i);
    if (i < 4) return 8'h01 << i;
    if (i < 7) return 8'h01 << (i - 4);
    return (i == F_WARNING) ? 8'h04 : 8'h01;
  endfunction
  function automatic int mask_bit(int i);
    int m[11] = '{0, 0, 1, 1, 3, 2, 4, 6, 5, 7, 2};
    return m[i];
  endfunction
  function automatic logic held(int i, logic [7:0] l, logic [7:0] m);
    if (i == F_CLOCK) return l[5] | m[7];
    if (i == F_SHUTDOWN) return l[4] & ~m[4];
    return l[3];
  endfunction
  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    step(1);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    step(1);
    reg_write = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    step(1);
    reg_addr = a;
    reg_read = 1'b1;
    step(1);
    reg_read = 1'b0;
    `CHK("rvalid", 1'b1, reg_rvalid)
    `CHK("rdata", e, reg_rdata)
  endtask
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    step(16);
    reset = 1'b0;
    for (int a = 'h70; a <= 'h78; a++) begin
      rd(8'(a), (a == 'h75) ? 8'hf8 : 8'h00);
    end
    for (int k = 0; k < 12; k++) begin
      r = xs();
      wr(8'h74 + 8'(k % 3), r[7:0]);
      rd(8'h74 + 8'(k % 3), r[7:0]);
    end
    wr(8'h72, r[15:8]);
    rd(8'h72, 8'h00);
    wr(8'h78, r[23:16]);
    rd(8'h78, r[23:16] & 8'h7f);
    wr(8'h74, 8'h00);
    wr(8'h75, 8'hf8);
    wr(8'h76, 8'h00);
    for (int i = 0; i < NUM_FAULTS; i++) begin
      raw[i] = 1'b1;
      step(int'(xs() % 4) + 3);
      raw[i] = 1'b0;
      step(5);
      if (addr_of(i) != 8'h00) rd(addr_of(i), byte_of(i));
      `CHK("report", i != F_WARNING, !fault_report_n)
      `CHK("warn", i == F_WARNING, !thermal_warning_report_n)
      if (i == F_WARNING) wr(8'h75, 8'hfc);
      else wr(8'h74, 8'h01 << mask_bit(i));
      step(2);
      `CHK("masked", 1'b1, fault_report_n & thermal_warning_report_n)
      `CHK("active", i == F_SHUTDOWN, thermal_shutdown_active)
      if (addr_of(i) != 8'h00) rd(addr_of(i), byte_of(i));
      wr(8'h78, 8'h80);
      `CHK("clear pulse", 1'b1, analog_fault_clear)
      wr(8'h74, 8'h00);
      wr(8'h75, 8'hf8);
      step(2);
      `CHK("cleared", 1'b1, fault_report_n)
      if (addr_of(i) != 8'h00) rd(addr_of(i), 8'h00);
    end
    for (int c = 0; c < 4; c++) begin
      for (int i = F_CLOCK; i <= F_WARNING; i++) begin
        if (i == F_CORE_LOW || i == F_CORE_HIGH) continue;
        wr(8'h75, c5[c]);
        wr(8'h76, c6[c]);
        raw[i] = 1'b1;
        step(6);
        raw[i] = 1'b0;
        step(6);
        rd(addr_of(i), held(i, c5[c], c6[c]) ? byte_of(i) : 8'h00);
        wr(8'h78, 8'h80);
      end
    end
    wr(8'h74, 8'hff);
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    rd(8'h74, 8'h00);
    rd(8'h75, 8'hf8);
    rd(8'h76, 8'h00);
    print_verdict();
  end
endmodule
